/* design/bit_byte_collector.sv */
// serial bit collector: shifts framer bits into a word
// assumes stb_i pulses once per received bit, same clock as the bank
`timescale 1ns/10ps
module bit_byte_collector #(
  parameter int W = 8,
  parameter bit MSB_FIRST = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stb_i,
  input wire logic bit_i,
  output logic [W-1:0] word_o,
  output logic full_o
);
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] LAST = CW'(W - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [W-1:0] word_q;
  logic full_q;

  ////////////////////////////////////////////////////////////////////////
  // start restarts the count so a slipped channel recovers in one word
  always_comb begin
    cnt_d = start_i ? '0 : cnt_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      full_q <= stb_i && (cnt_d == LAST);
      if (stb_i) begin
        cnt_q <= (cnt_d == LAST) ? '0 : cnt_d + CW'(1);
      end else begin
        cnt_q <= cnt_d;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_q <= '0;
    end else if (stb_i) begin
      word_q <= MSB_FIRST ? {word_q[W-2:0], bit_i} : {bit_i, word_q[W-1:1]};
    end
  end

  assign word_o = word_q;
  assign full_o = full_q;
endmodule // bit_byte_collector

/* design/rx_overhead_capture_pkg.sv */
// package: offsets, field layout and carriers of the receive capture bank
// assumes one receive framer per port, clocked with the register bus
// Operation
// - monitor byte holds selected channel, first received bit in bit 7
// - t1 data link byte reports link or fs bits, earliest bit lowest
// - superframe mode updates link byte at multiframe end, fs bits low six
// - bit code register holds last valid six-bit code, bits 7:6 zero
// - e1 sync counter counts each failed crc-4 multiframe search window
// - sync counter clears on crc-4 sync or when crc-4 enable is off
// - sync counter saturates at its maximum instead of wrapping
// - six-bit count shows bits 5,4,3,2,0 in register bits 7:3
// - status bit 2 is high while hunting crc-4 multiframe word
// - status bit 1 is high while hunting cas multiframe word
// - status bit 0 is high while hunting frame alignment
// - real-time status bits come from current state, never latched
// - shared addresses decode by mode: t1 link byte, e1 status
// - t1 data link spans three registers of c, spoiler, m, a, s bits
// - e1 align-frame byte: si in bit 7, alignment bits below
// - e1 non-align byte: si, one, remote alarm, sa4 to sa8
// - si bits of even frames 0..14 packed, frame 14 in bit 7
// - si bits of odd frames 1..15 packed, frame 15 in bit 7
// - remote alarm bits of odd frames packed, frame 15 in bit 7
// - sa4 bits of odd frames packed, frame 15 in bit 7
// - four ports repeat the map at a stride of 200h registers
// - receive mode bit zero selects t1, one selects e1
package rx_overhead_capture_pkg;
  localparam int NPORTS = 4;
  localparam int ADR_TOP = 13;
  localparam int PORT_MSB = 12;
  localparam int PORT_LSB = 11;
  localparam int OFF_MSB = 10;
  localparam int OFF_LSB = 2;
  localparam logic [8:0] IDX_TS_MON = 9'h060;
  localparam logic [8:0] IDX_DL = 9'h062;
  localparam logic [8:0] IDX_BOC = 9'h063;
  localparam logic [8:0] IDX_OH1 = 9'h064;
  localparam logic [8:0] IDX_OH2 = 9'h065;
  localparam logic [8:0] IDX_OH3 = 9'h066;
  localparam logic [8:0] IDX_SI_ODD = 9'h067;
  localparam logic [8:0] IDX_RA = 9'h068;
  localparam logic [8:0] IDX_SA4 = 9'h069;
  localparam logic [8:0] IDX_CHAN = 9'h07e;
  localparam logic [8:0] IDX_MODE = 9'h080;
  localparam logic [8:0] IDX_CTRL = 9'h081;
  localparam int MODE_E1_BIT = 0;
  localparam int CRC4_EN_BIT = 3;
  localparam int D4_BIT = 5;
  localparam logic [7:0] MODE_MASK = 8'h01;
  localparam logic [7:0] CHAN_MASK = 8'h1f;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CSC_W = 6;
  localparam logic [5:0] CSC_MAX = 6'h3f;
  localparam logic [2:0] SLC2_SPOIL = 3'h2;
  localparam logic SLC3_SPOIL = 1'b1;
  localparam logic NAF_FIXED = 1'b1;

  typedef struct packed {
    logic ts_stb;
    logic ts_bit;
    logic ts_start;
    logic dl_stb;
    logic dl_bit;
    logic dl_end;
    logic boc_stb;
    logic [5:0] boc;
    logic slc_stb;
    logic [10:0] slc_c;
    logic [2:0] slc_m;
    logic [1:0] slc_a;
    logic [3:0] slc_s;
    logic ts0_stb;
    logic ts0_align;
    logic [3:0] ts0_frame;
    logic [7:0] ts0_byte;
    logic crc4_timeout;
    logic crc4_sync;
    logic crc4_sa;
    logic cas_sa;
    logic fas_sa;
  } framer_evt_s;

  typedef struct packed {
    logic [7:0] ts;
    logic [7:0] dl;
    logic [5:0] boc;
    logic [7:0] slc1;
    logic [7:0] slc2;
    logic [7:0] slc3;
  } t1_cap_s;

  typedef struct packed {
    logic [7:0] af;
    logic [7:0] naf;
    logic [7:0] si_even;
    logic [7:0] si_odd;
    logic [7:0] ra;
    logic [7:0] sa4;
  } e1_cap_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] chan;
  } control_s;

  function automatic logic adr_hit(input logic [31:0] a);
    return a[31:ADR_TOP] == '0;
  endfunction

  function automatic logic [1:0] adr_port(input logic [31:0] a);
    return a[PORT_MSB:PORT_LSB];
  endfunction

  function automatic logic [8:0] adr_off(input logic [31:0] a);
    return a[OFF_MSB:OFF_LSB];
  endfunction
endpackage

/* design/rx_overhead_capture_regs.sv */
// receive overhead capture bank, four ports, classic wishbone slave
// assumes framer event inputs are synchronous to clk_i, one-cycle strobes
`timescale 1ns/10ps
module rx_overhead_capture_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire rx_overhead_capture_pkg::framer_evt_s [rx_overhead_capture_pkg::NPORTS-1:0] framer_i,
  output rx_overhead_capture_pkg::control_s [rx_overhead_capture_pkg::NPORTS-1:0] ctrl_o
);
  localparam int NP = rx_overhead_capture_pkg::NPORTS;

  rx_overhead_capture_pkg::t1_cap_s [NP-1:0] t1_q;
  rx_overhead_capture_pkg::e1_cap_s [NP-1:0] e1_q;
  rx_overhead_capture_pkg::control_s [NP-1:0] ctl_q;
  logic [NP-1:0][rx_overhead_capture_pkg::CSC_W-1:0] csc_q;
  logic [NP-1:0][7:0] ts_word;
  logic [NP-1:0][7:0] dl_word;
  logic [NP-1:0] ts_full;
  logic [NP-1:0] e1_mode;
  logic [NP-1:0] d4_mode;
  logic [NP-1:0] crc4_en;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic [1:0] req_port;
  logic [8:0] req_off;
  logic req_hit;

  ////////////////////////////////////////////////////////////////////////
  // mode bits seen by the capture logic

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      e1_mode[p] = ctl_q[p].mode[rx_overhead_capture_pkg::MODE_E1_BIT];
      d4_mode[p] = ctl_q[p].ctrl[rx_overhead_capture_pkg::D4_BIT];
      crc4_en[p] = ctl_q[p].ctrl[rx_overhead_capture_pkg::CRC4_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial collectors for the monitored channel and the data link

  for (genvar g = 0; g < NP; g++) begin : g_col
    bit_byte_collector #(
      .W(8),
      .MSB_FIRST(1'b1)
    ) u_ts (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(framer_i[g].ts_start),
      .stb_i(framer_i[g].ts_stb),
      .bit_i(framer_i[g].ts_bit),
      .word_o(ts_word[g]),
      .full_o(ts_full[g])
    );
    // link bits enter at the top so the earliest ends lowest
    bit_byte_collector #(
      .W(8),
      .MSB_FIRST(1'b0)
    ) u_dl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(framer_i[g].dl_end),
      .stb_i(framer_i[g].dl_stb),
      .bit_i(framer_i[g].dl_bit),
      .word_o(dl_word[g]),
      .full_o()
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // t1 captures

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (ts_full[p]) begin
          t1_q[p].ts <= ts_word[p];
        end
        if (!e1_mode[p] && framer_i[p].dl_end) begin
          if (d4_mode[p]) begin
            t1_q[p].dl <= {2'h0, dl_word[p][7:2]};
          end else begin
            t1_q[p].dl <= dl_word[p];
          end
        end
        if (!e1_mode[p] && framer_i[p].boc_stb) begin
          t1_q[p].boc <= framer_i[p].boc;
        end
        if (!e1_mode[p] && framer_i[p].slc_stb) begin
          t1_q[p].slc1 <= framer_i[p].slc_c[7:0];
          t1_q[p].slc2 <= {framer_i[p].slc_m[1:0], rx_overhead_capture_pkg::SLC2_SPOIL,
                           framer_i[p].slc_c[10:8]};
          t1_q[p].slc3 <= {rx_overhead_capture_pkg::SLC3_SPOIL, framer_i[p].slc_s,
                           framer_i[p].slc_a, framer_i[p].slc_m[2]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // e1 timeslot-zero captures; frame number picks the bit slot

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e1_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (e1_mode[p] && framer_i[p].ts0_stb) begin
          if (framer_i[p].ts0_align) begin
            e1_q[p].af <= framer_i[p].ts0_byte;
            e1_q[p].si_even[framer_i[p].ts0_frame[3:1]] <= framer_i[p].ts0_byte[7];
          end else begin
            e1_q[p].naf <= framer_i[p].ts0_byte;
            e1_q[p].si_odd[framer_i[p].ts0_frame[3:1]] <= framer_i[p].ts0_byte[7];
            e1_q[p].ra[framer_i[p].ts0_frame[3:1]] <= framer_i[p].ts0_byte[5];
            e1_q[p].sa4[framer_i[p].ts0_frame[3:1]] <= framer_i[p].ts0_byte[4];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crc-4 sync counter; clear outranks a timeout in the same cycle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csc_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (!crc4_en[p] || framer_i[p].crc4_sync) begin
          csc_q[p] <= '0;
        end else if (e1_mode[p] && framer_i[p].crc4_timeout &&
                     csc_q[p] != rx_overhead_capture_pkg::CSC_MAX) begin
          csc_q[p] <= csc_q[p] + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; status bits are taken live, so a read sees this cycle's hunt

  function automatic logic [7:0] status_byte(input logic [5:0] c,
                                             input rx_overhead_capture_pkg::framer_evt_s e);
    // counter bit 1 is dropped so five bits still reach past the full count
    return {c[5:2], c[0], e.crc4_sa, e.cas_sa, e.fas_sa};
  endfunction

  function automatic logic [7:0] read_byte(input int p, input logic [8:0] off);
    logic e1;
    e1 = e1_mode[p];
    case (off)
      rx_overhead_capture_pkg::IDX_TS_MON: read_byte = t1_q[p].ts;
      rx_overhead_capture_pkg::IDX_DL:
        read_byte = e1 ? status_byte(csc_q[p], framer_i[p]) : t1_q[p].dl;
      rx_overhead_capture_pkg::IDX_BOC: read_byte = e1 ? 8'h00 : {2'h0, t1_q[p].boc};
      rx_overhead_capture_pkg::IDX_OH1: read_byte = e1 ? e1_q[p].af : t1_q[p].slc1;
      rx_overhead_capture_pkg::IDX_OH2: read_byte = e1 ? e1_q[p].naf : t1_q[p].slc2;
      rx_overhead_capture_pkg::IDX_OH3: read_byte = e1 ? e1_q[p].si_even : t1_q[p].slc3;
      rx_overhead_capture_pkg::IDX_SI_ODD: read_byte = e1 ? e1_q[p].si_odd : 8'h00;
      rx_overhead_capture_pkg::IDX_RA: read_byte = e1 ? e1_q[p].ra : 8'h00;
      rx_overhead_capture_pkg::IDX_SA4: read_byte = e1 ? e1_q[p].sa4 : 8'h00;
      rx_overhead_capture_pkg::IDX_CHAN: read_byte = ctl_q[p].chan;
      rx_overhead_capture_pkg::IDX_MODE: read_byte = ctl_q[p].mode;
      rx_overhead_capture_pkg::IDX_CTRL: read_byte = ctl_q[p].ctrl;
      default: read_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone classic slave: one wait state, unmapped reads give zero

  always_comb begin
    req = cyc_i && stb_i && !ack_q;
    req_hit = rx_overhead_capture_pkg::adr_hit(adr_i);
    req_port = rx_overhead_capture_pkg::adr_port(adr_i);
    req_off = rx_overhead_capture_pkg::adr_off(adr_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !we_i && req_hit) begin
        dat_q <= {24'h0, read_byte(int'(req_port), req_off)};
      end else if (req) begin
        dat_q <= '0;
      end
    end
  end

  // only the steering registers take writes; capture addresses drop them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= '0;
    end else if (req && we_i && req_hit && sel_i[0]) begin
      case (req_off)
        rx_overhead_capture_pkg::IDX_MODE:
          ctl_q[req_port].mode <= dat_i[7:0] & rx_overhead_capture_pkg::MODE_MASK;
        rx_overhead_capture_pkg::IDX_CTRL: ctl_q[req_port].ctrl <= dat_i[7:0];
        rx_overhead_capture_pkg::IDX_CHAN:
          ctl_q[req_port].chan <= dat_i[7:0] & rx_overhead_capture_pkg::CHAN_MASK;
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign ctrl_o = ctl_q;

  ////////////////////////////////////////////////////////////////////////
  // checks on port 0; the ack and unmapped-read checks cover every port

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  rx_overhead_capture_pkg::framer_evt_s e0;
  logic rd_dl0;
  assign e0 = framer_i[0];
  assign rd_dl0 = req && !we_i && req_hit && req_port == 2'h0 &&
                  req_off == rx_overhead_capture_pkg::IDX_DL;

  property p_ts_capture;
    ts_full[0] |=> t1_q[0].ts == $past(ts_word[0]);
  endproperty
  a_ts_capture: assert property (p_ts_capture) else $error("monitor byte not loaded");

  property p_dl_fdl;
    e0.dl_end && !e1_mode[0] && !d4_mode[0] |=> t1_q[0].dl == $past(dl_word[0]);
  endproperty
  a_dl_fdl: assert property (p_dl_fdl) else $error("link byte wrong");

  property p_dl_sf;
    e0.dl_end && !e1_mode[0] && d4_mode[0]
      |=> t1_q[0].dl == {2'h0, $past(dl_word[0][7:2])};
  endproperty
  a_dl_sf: assert property (p_dl_sf) else $error("fs bits misplaced");

  property p_boc;
    e0.boc_stb && !e1_mode[0] |=> t1_q[0].boc == $past(e0.boc);
  endproperty
  a_boc: assert property (p_boc) else $error("bit code not held");

  property p_csc_inc;
    crc4_en[0] && e1_mode[0] && !e0.crc4_sync && e0.crc4_timeout &&
      csc_q[0] != rx_overhead_capture_pkg::CSC_MAX |=> csc_q[0] == $past(csc_q[0]) + 6'h01;
  endproperty
  a_csc_inc: assert property (p_csc_inc) else $error("counter missed timeout");

  property p_csc_clr;
    !crc4_en[0] || e0.crc4_sync |=> csc_q[0] == '0;
  endproperty
  a_csc_clr: assert property (p_csc_clr) else $error("counter not cleared");

  property p_csc_sat;
    crc4_en[0] && !e0.crc4_sync && csc_q[0] == rx_overhead_capture_pkg::CSC_MAX
      |=> csc_q[0] == rx_overhead_capture_pkg::CSC_MAX;
  endproperty
  a_csc_sat: assert property (p_csc_sat) else $error("counter wrapped");

  property p_status_rd;
    rd_dl0 && e1_mode[0]
      |=> ack_o && dat_o[7:0] == $past(status_byte(csc_q[0], e0));
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_si_even;
    e0.ts0_stb && e0.ts0_align && e1_mode[0]
      |=> e1_q[0].si_even[$past(e0.ts0_frame[3:1])] == $past(e0.ts0_byte[7]);
  endproperty
  a_si_even: assert property (p_si_even) else $error("even si bit lost");

  property p_ack;
    req |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  property p_af;
    e0.ts0_stb && e0.ts0_align && e1_mode[0] |=> e1_q[0].af == $past(e0.ts0_byte);
  endproperty
  a_af: assert property (p_af) else $error("align byte not held");

  property p_naf;
    e0.ts0_stb && !e0.ts0_align && e1_mode[0] |=> e1_q[0].naf == $past(e0.ts0_byte);
  endproperty
  a_naf: assert property (p_naf) else $error("non-align byte not held");

  property p_si_odd;
    e0.ts0_stb && !e0.ts0_align && e1_mode[0]
      |=> e1_q[0].si_odd[$past(e0.ts0_frame[3:1])] == $past(e0.ts0_byte[7]);
  endproperty
  a_si_odd: assert property (p_si_odd) else $error("odd si bit lost");

  property p_ra;
    e0.ts0_stb && !e0.ts0_align && e1_mode[0]
      |=> e1_q[0].ra[$past(e0.ts0_frame[3:1])] == $past(e0.ts0_byte[5]);
  endproperty
  a_ra: assert property (p_ra) else $error("remote alarm bit lost");

  property p_sa4;
    e0.ts0_stb && !e0.ts0_align && e1_mode[0]
      |=> e1_q[0].sa4[$past(e0.ts0_frame[3:1])] == $past(e0.ts0_byte[4]);
  endproperty
  a_sa4: assert property (p_sa4) else $error("sa4 bit lost");

  property p_slc;
    e0.slc_stb && !e1_mode[0] |=> t1_q[0].slc1 == $past(e0.slc_c[7:0]) &&
      t1_q[0].slc2[5:3] == rx_overhead_capture_pkg::SLC2_SPOIL;
  endproperty
  a_slc: assert property (p_slc) else $error("data link registers wrong");

  property p_rd_zero;
    req && !we_i && !req_hit |=> dat_o == '0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");

  property p_chan_wr;
    req && we_i && req_hit && sel_i[0] && req_port == 2'h0 &&
      req_off == rx_overhead_capture_pkg::IDX_CHAN
      |=> ctl_q[0].chan == ($past(dat_i[7:0]) & rx_overhead_capture_pkg::CHAN_MASK);
  endproperty
  a_chan_wr: assert property (p_chan_wr) else $error("channel select not stored");

  c_csc_full: cover property (csc_q[0] == rx_overhead_capture_pkg::CSC_MAX);
  c_e1_read: cover property (rd_dl0 && e1_mode[0]);
  c_sf_commit: cover property (e0.dl_end && d4_mode[0] && !e1_mode[0]);
  c_naf_frame: cover property (e0.ts0_stb && !e0.ts0_align && e1_mode[0]);
  c_ts_byte: cover property (ts_full[0]);
endmodule // rx_overhead_capture_regs

/* testbench/framer_line_model.sv */
// far-end line model: presents receive framer events to every port of the bank
// assumes the bank samples events on the rising edge of clk_i
`timescale 1ns/10ps
module framer_line_model (
  input wire logic clk_i,
  output rx_overhead_capture_pkg::framer_evt_s [rx_overhead_capture_pkg::NPORTS-1:0] framer_o
);
  logic [2:0] lv [4];
  initial begin
    framer_o = '0;
    for (int i = 0; i < 4; i++) lv[i] = 3'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one event cycle; data then flips to its inverse so stale values never match
  task automatic pulse(input int p, input rx_overhead_capture_pkg::framer_evt_s e);
    rx_overhead_capture_pkg::framer_evt_s h;
    h = ~e;
    {h.ts_stb, h.ts_start, h.dl_stb, h.dl_end, h.boc_stb, h.slc_stb} = 6'h00;
    {h.ts0_stb, h.crc4_timeout, h.crc4_sync} = 3'h0;
    {e.crc4_sa, e.cas_sa, e.fas_sa} = lv[p];
    {h.crc4_sa, h.cas_sa, h.fas_sa} = lv[p];
    @(posedge clk_i);
    framer_o[p] <= e;
    @(posedge clk_i);
    framer_o[p] <= h;
  endtask
  // search levels persist between events
  task automatic set_levels(input int p, input logic [2:0] v);
    lv[p] = v;
    pulse(p, '0);
  endtask
  task automatic ts_byte(input int p, input logic [7:0] b);
    rx_overhead_capture_pkg::framer_evt_s e;
    for (int i = 0; i < 8; i++) begin
      e = '0;
      e.ts_stb = 1'b1;
      e.ts_bit = b[7-i];
      e.ts_start = (i == 0);
      pulse(p, e);
    end
  endtask
  // link bits go earliest first, framed by boundary pulses
  task automatic dl_bits(input int p, input logic [7:0] b, input int n);
    rx_overhead_capture_pkg::framer_evt_s e;
    e = '0;
    e.dl_end = 1'b1;
    pulse(p, e);
    for (int i = 0; i < n; i++) begin
      e = '0;
      e.dl_stb = 1'b1;
      e.dl_bit = b[i];
      pulse(p, e);
    end
    e = '0;
    e.dl_end = 1'b1;
    pulse(p, e);
  endtask
endmodule // framer_line_model

/* testbench/tb_rx_overhead_capture_regs.sv */
// testbench: wishbone host reads the capture bank while the line model feeds events
// assumes a 20 MHz clock and the framer line model beside the bank
`timescale 1ns/10ps
module tb_rx_overhead_capture_regs;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  rx_overhead_capture_pkg::framer_evt_s [3:0] evt;
  rx_overhead_capture_pkg::control_s [3:0] ctrl;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  rx_overhead_capture_regs u_rx_overhead_capture_regs (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .framer_i(evt), .ctrl_o(ctrl));
  framer_line_model u_framer_line_model (.clk_i(clk_i), .framer_o(evt));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] radr(input int p, input logic [8:0] idx);
    return 32'(idx) * 32'h4 + 32'(p) * 32'h800;
  endfunction
  // classic cycle: held until ack is sampled, then released for one idle cycle
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input int p, input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, radr(p, idx), d, q);
  endtask
  task automatic rd_chk(input int p, input logic [8:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, radr(p, idx), 8'h00, q);
    chk(q, {24'h0, exp});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [31:0] q;
    rd_chk(0, 9'h060, 8'h00);
    rd_chk(3, 9'h069, 8'h00);
    wr(0, 9'h060, 8'hff);
    rd_chk(0, 9'h060, 8'h00);
    wr(0, 9'h07e, 8'hff);
    rd_chk(0, 9'h07e, 8'h1f);
    wb(1'b0, 32'h8000_0000, 8'h00, q);
    chk(q, 32'h0);
  endtask
  task automatic test_t1();
    rx_overhead_capture_pkg::framer_evt_s e;
    u_framer_line_model.ts_byte(0, 8'ha6);
    rd_chk(0, 9'h060, 8'ha6);
    u_framer_line_model.dl_bits(0, 8'h35, 8);
    rd_chk(0, 9'h062, 8'h35);
    e = '0;
    e.boc_stb = 1'b1;
    e.boc = 6'h2b;
    u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h063, 8'h2b);
    e = '0;
    e.slc_stb = 1'b1;
    e.slc_c = 11'h5a3;
    e.slc_m = 3'h5;
    e.slc_a = 2'h2;
    e.slc_s = 4'h9;
    u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h064, e.slc_c[7:0]);
    rd_chk(0, 9'h065, {e.slc_m[1:0], 3'b010, e.slc_c[10:8]});
    rd_chk(0, 9'h066, {1'b1, e.slc_s, e.slc_a, e.slc_m[2]});
    wr(0, 9'h081, 8'h20);
    u_framer_line_model.dl_bits(0, 8'h2d, 6);
    rd_chk(0, 9'h062, 8'h2d);
  endtask
  task automatic test_e1_frames();
    rx_overhead_capture_pkg::framer_evt_s e;
    logic [15:0] si;
    logic [7:0] ra, sa4, ev, od;
    si = 16'hc3a5;
    ra = 8'h96;
    sa4 = 8'h3c;
    wr(2, 9'h080, 8'h01);
    chk({24'h0, ctrl[2].mode}, 32'h1);
    for (int f = 0; f < 16; f++) begin
      e = '0;
      e.ts0_stb = 1'b1;
      e.ts0_frame = 4'(f);
      e.ts0_align = (f % 2 == 0);
      if (f % 2 == 0) e.ts0_byte = {si[f], 7'h1b};
      else e.ts0_byte = {si[f], 1'b1, ra[f/2], sa4[f/2], 4'ha};
      if (f % 2 == 0) ev[f/2] = si[f];
      else od[f/2] = si[f];
      u_framer_line_model.pulse(2, e);
    end
    rd_chk(2, 9'h064, {si[14], 7'h1b});
    rd_chk(2, 9'h065, {si[15], 1'b1, ra[7], sa4[7], 4'ha});
    rd_chk(2, 9'h066, ev);
    rd_chk(2, 9'h067, od);
    rd_chk(2, 9'h068, ra);
    rd_chk(2, 9'h069, sa4);
    rd_chk(0, 9'h062, 8'h2d);
  endtask
  task automatic test_sync_count();
    rx_overhead_capture_pkg::framer_evt_s e, s;
    e = '0;
    e.crc4_timeout = 1'b1;
    s = '0;
    s.crc4_sync = 1'b1;
    // port 0 so the counter and timeslot-zero checks in the bank see traffic
    wr(0, 9'h080, 8'h01);
    wr(0, 9'h081, 8'h08);
    u_framer_line_model.set_levels(0, 3'b101);
    repeat (5) u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h062, {4'h1, 1'b1, 3'b101});
    u_framer_line_model.set_levels(0, 3'b010);
    rd_chk(0, 9'h062, {4'h1, 1'b1, 3'b010});
    // 65 timeouts: a wrapping counter would read back as one
    repeat (60) u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h062, {4'hf, 1'b1, 3'b010});
    u_framer_line_model.pulse(0, s);
    rd_chk(0, 9'h062, {5'h00, 3'b010});
    repeat (6) u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h062, {4'h1, 1'b0, 3'b010});
    wr(0, 9'h081, 8'h00);
    rd_chk(0, 9'h062, {5'h00, 3'b010});
    e = '0;
    e.ts0_stb = 1'b1;
    e.ts0_align = 1'b1;
    e.ts0_frame = 4'h6;
    e.ts0_byte = 8'h9b;
    u_framer_line_model.pulse(0, e);
    e.ts0_align = 1'b0;
    e.ts0_frame = 4'h7;
    e.ts0_byte = 8'he5;
    u_framer_line_model.pulse(0, e);
    rd_chk(0, 9'h064, 8'h9b);
    rd_chk(0, 9'h066, 8'h08);
    rd_chk(0, 9'h065, 8'he5);
    rd_chk(0, 9'h067, 8'h08);
    rd_chk(0, 9'h068, 8'h08);
    rd_chk(0, 9'h069, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_t1();
    test_e1_frames();
    test_sync_count();
    end_sim();
  end
endmodule // tb_rx_overhead_capture_regs
